// *** mli_pkg.sv ***
// Constants and types for the mesh node indicator lamp controller
package mli_pkg;
  localparam int unsigned CLK_HZ            = 25_000_000;
  localparam int unsigned TICK_MS           = 100;
  localparam int unsigned TICK_CYCLES       = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICK_W            = 22;
  localparam int unsigned TICKS_PER_MIN     = 600;
  localparam int unsigned MINUTE_W          = 10;
  localparam int unsigned PHASE_W           = 6;
  localparam logic [5:0]  PHASE_WRAP        = 6'h27;
  localparam logic [5:0]  HALF_FAST         = 6'h01;
  localparam logic [5:0]  HALF_ONE_SEC      = 6'h0a;
  localparam logic [5:0]  HALF_TWO_SEC      = 6'h14;
  localparam int unsigned BEAT_W            = 3;
  localparam logic [2:0]  BEAT_WRAP         = 3'h4;
  localparam logic [2:0]  BEAT_LIT          = 3'h2;
  localparam logic [7:0]  MINUTES_MAX       = 8'hff;
  localparam logic [7:0]  ON_TIME_FOREVER   = 8'hff;
  localparam logic [7:0]  ON_TIME_END_NODE  = 8'h01;
  localparam logic [7:0]  ON_TIME_DISABLED  = 8'h00;
  localparam logic [7:0]  CLUSTER_SIG_DEF   = 8'h3c;
  localparam logic [7:0]  CLUSTER_LIMIT_DEF = 8'h0a;
  localparam int unsigned FLASH_MS          = 50;
  localparam int unsigned FLASH_CYCLES      = CLK_HZ / 1000 * FLASH_MS;
  localparam int unsigned FLASH_W           = 21;

  typedef enum logic [3:0] {
    MLI_SIG_TOP  = 4'b0001,
    MLI_SIG_GOOD = 4'b0010,
    MLI_SIG_OK   = 4'b0100,
    MLI_SIG_LOW  = 4'b1000
  } mli_sig_e;

  typedef enum logic [2:0] {
    MLI_ROLE_GATEWAY = 3'b001,
    MLI_ROLE_ROUTER  = 3'b010,
    MLI_ROLE_END     = 3'b100
  } mli_role_e;

  typedef enum logic [2:0] {
    MLI_TOPO_NONE    = 3'b000,
    MLI_TOPO_GW_MULTI = 3'b001,
    MLI_TOPO_GW_ONE  = 3'b010,
    MLI_TOPO_RT_MULTI = 3'b011,
    MLI_TOPO_RT_ONE  = 3'b100
  } mli_topo_e;
endpackage : mli_pkg

// *** mli_flash.sv ***
// One-shot lamp flash stretcher for packet events
`timescale 1ns/10ps
module mli_flash (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Event in, lamp out
  input  wire logic trig,
  output logic      lamp
);
  logic [mli_pkg::FLASH_W-1:0] cnt_q;

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_q <= '0;
    else if (trig)
      cnt_q <= mli_pkg::FLASH_W'(mli_pkg::FLASH_CYCLES);
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end

  assign lamp = (cnt_q != '0);
endmodule : mli_flash

// *** mli_top.sv ***
// Mesh node indicator lamp controller top
`timescale 1ns/10ps
module mli_top (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Role and configuration
  input  wire logic [2:0] role,
  input  wire logic       end_node_cmd,
  input  wire logic       on_time_wr,
  input  wire logic [7:0] on_time_wdata,
  input  wire logic       config_mode,
  input  wire logic       fixed_dest,
  input  wire logic       cluster_sig_wr,
  input  wire logic [7:0] cluster_sig_wdata,
  input  wire logic       cluster_lim_wr,
  input  wire logic [7:0] cluster_lim_wdata,
  // Link quality
  input  wire logic [7:0] signal_level,
  input  wire logic [7:0] top_signal_threshold,
  input  wire logic [7:0] min_signal_threshold,
  input  wire logic [7:0] link_switch_margin,
  input  wire logic [2:0] topology,
  // Packet events, one-cycle pulses
  input  wire logic       tx_packet,
  input  wire logic       rx_packet,
  input  wire logic       rx_valid,
  // Pulse counter feedback
  input  wire logic       pulse_fb_in,
  // Cluster detection
  input  wire logic [7:0] cluster_count,
  input  wire logic [7:0] neighbour_level,
  // Outputs
  output logic            signal_tx_lamp,
  output logic            link_rx_lamp,
  output logic            pulse_fb_out,
  output logic            lamps_enabled,
  output logic [7:0]      on_time,
  output logic [7:0]      cluster_signal_threshold,
  output logic [7:0]      cluster_limit,
  output logic            cluster_reduce,
  output logic            new_link_allowed
);
  logic [mli_pkg::TICK_W-1:0]   tick_cnt_q;
  logic                         tick;
  logic [mli_pkg::PHASE_W-1:0]  phase_q;
  logic [mli_pkg::MINUTE_W-1:0] min_cnt_q;
  logic [7:0]                   on_time_q;
  logic [7:0]                   minutes_q;
  logic                         active_q;
  logic [7:0]                   clu_sig_q;
  logic [7:0]                   clu_lim_q;
  logic                         sig_lamp_q;
  logic                         link_lamp_q;
  logic                         fb_q;
  logic                         fb_meta_q;
  logic                         fb_sync_q;
  logic                         tx_flash;
  logic                         rx_flash;
  logic                         is_gateway;
  logic [3:0]                   sig_class;
  logic                         pat5;
  logic                         pat2;
  logic                         pat1s;
  logic                         pat2s;
  logic [8:0]                   good_floor;
  logic [mli_pkg::BEAT_W-1:0]   beat_q;
  logic                         reduce_q;
  logic                         link_ok_q;

  // Tick every 100 ms; phase spans a 4 s frame of 40 ticks
  // Every phase pattern's half period is a whole number of ticks, so patterns never drift
  assign tick = (tick_cnt_q == mli_pkg::TICK_W'(mli_pkg::TICK_CYCLES - 1));

  always_ff @(posedge clk)
  begin
    if (rst)
      tick_cnt_q <= '0;
    else if (tick)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      phase_q <= '0;
    else if (tick)
      phase_q <= (phase_q == mli_pkg::PHASE_WRAP) ? '0 : phase_q + 1'b1;
  end

  // Two-per-second beat of five ticks; a counter avoids dividing the phase
  always_ff @(posedge clk)
  begin
    if (rst)
      beat_q <= '0;
    else if (tick)
      beat_q <= (beat_q == mli_pkg::BEAT_WRAP) ? '0 : beat_q + 1'b1;
  end

  // Fast, one- and two-second patterns are 50% duty squares of the phase
  function automatic logic pattern(input logic [5:0] ph, input logic [5:0] half);
    logic [6:0] full;
    logic [5:0] rem;
    full = {half, 1'b0};
    rem  = 6'(ph % full);
    return rem < half;
  endfunction : pattern

  assign pat5  = pattern(phase_q, mli_pkg::HALF_FAST);
  assign pat2  = (beat_q < mli_pkg::BEAT_LIT);
  assign pat1s = pattern(phase_q, mli_pkg::HALF_ONE_SEC);
  assign pat2s = pattern(phase_q, mli_pkg::HALF_TWO_SEC);

  // On-time setting and configuration thresholds
  // End-node command beats a same-cycle write, so the mode switch always applies
  always_ff @(posedge clk)
  begin
    if (rst)
      on_time_q <= mli_pkg::ON_TIME_FOREVER;
    else if (end_node_cmd)
      on_time_q <= mli_pkg::ON_TIME_END_NODE;
    else if (on_time_wr)
      on_time_q <= on_time_wdata;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      clu_sig_q <= mli_pkg::CLUSTER_SIG_DEF;
    else if (cluster_sig_wr)
      clu_sig_q <= cluster_sig_wdata;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      clu_lim_q <= mli_pkg::CLUSTER_LIMIT_DEF;
    else if (cluster_lim_wr)
      clu_lim_q <= cluster_lim_wdata;
  end

  // Minute counter since reset; saturates so it never wraps into active
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      min_cnt_q <= '0;
      minutes_q <= '0;
    end
    else if (tick)
    begin
      if (min_cnt_q == mli_pkg::MINUTE_W'(mli_pkg::TICKS_PER_MIN - 1))
      begin
        min_cnt_q <= '0;
        if (minutes_q != mli_pkg::MINUTES_MAX)
          minutes_q <= minutes_q + 1'b1;
      end
      else
        min_cnt_q <= min_cnt_q + 1'b1;
    end
  end

  // Level compare, so raising the on-time later lights the lamps again
  always_ff @(posedge clk)
  begin
    if (rst)
      active_q <= 1'b1;
    else if (on_time_q == mli_pkg::ON_TIME_DISABLED)
      active_q <= 1'b0;
    else if (on_time_q == mli_pkg::ON_TIME_FOREVER)
      active_q <= 1'b1;
    else
      active_q <= (minutes_q < on_time_q);
  end

  // Signal class relative to thresholds
  assign good_floor = {1'b0, min_signal_threshold} + {1'b0, link_switch_margin};
  always_comb
  begin
    if (signal_level > top_signal_threshold)
      sig_class = mli_pkg::MLI_SIG_TOP;
    else if ({1'b0, signal_level} >= good_floor)
      sig_class = mli_pkg::MLI_SIG_GOOD;
    else if (signal_level >= min_signal_threshold)
      sig_class = mli_pkg::MLI_SIG_OK;
    else
      sig_class = mli_pkg::MLI_SIG_LOW;
  end

  assign is_gateway = (role == mli_pkg::MLI_ROLE_GATEWAY);

  // Gateway packet flashes; invalid receptions are dropped here
  // A packet during a running flash restarts it, so bursts merge into one
  mli_flash u_tx_flash (
    .clk  (clk),
    .rst  (rst),
    .trig (tx_packet),
    .lamp (tx_flash)
  );

  mli_flash u_rx_flash (
    .clk  (clk),
    .rst  (rst),
    .trig (rx_packet & rx_valid),
    .lamp (rx_flash)
  );

  // Signal lamp: config, then time-out, then role state
  always_ff @(posedge clk)
  begin
    if (rst)
      sig_lamp_q <= 1'b0;
    else if (config_mode)
      sig_lamp_q <= 1'b1;
    else if (!active_q)
      sig_lamp_q <= 1'b0;
    else if (is_gateway)
      sig_lamp_q <= tx_flash;
    else
    begin
      case (sig_class)
        mli_pkg::MLI_SIG_TOP:  sig_lamp_q <= pat5;
        mli_pkg::MLI_SIG_GOOD: sig_lamp_q <= pat2;
        mli_pkg::MLI_SIG_OK:   sig_lamp_q <= pat1s;
        mli_pkg::MLI_SIG_LOW:  sig_lamp_q <= pat2s;
        default:               sig_lamp_q <= 1'b0;
      endcase
    end
  end

  // Link lamp; fixed destination follows the signal pattern
  // Config outranks time-out, so a timed-out node still shows config mode
  always_ff @(posedge clk)
  begin
    if (rst)
      link_lamp_q <= 1'b0;
    else if (config_mode)
      link_lamp_q <= 1'b1;
    else if (!active_q)
      link_lamp_q <= 1'b0;
    else if (is_gateway)
      link_lamp_q <= rx_flash;
    else if (fixed_dest)
    begin
      case (sig_class)
        mli_pkg::MLI_SIG_TOP:  link_lamp_q <= pat5;
        mli_pkg::MLI_SIG_GOOD: link_lamp_q <= pat2;
        mli_pkg::MLI_SIG_OK:   link_lamp_q <= pat1s;
        mli_pkg::MLI_SIG_LOW:  link_lamp_q <= pat2s;
        default:               link_lamp_q <= 1'b0;
      endcase
    end
    else
    begin
      case (topology)
        mli_pkg::MLI_TOPO_GW_MULTI: link_lamp_q <= 1'b1;
        mli_pkg::MLI_TOPO_GW_ONE:   link_lamp_q <= pat5;
        mli_pkg::MLI_TOPO_RT_MULTI: link_lamp_q <= pat2;
        mli_pkg::MLI_TOPO_RT_ONE:   link_lamp_q <= pat1s;
        default:                    link_lamp_q <= 1'b0;
      endcase
    end
  end

  // Feedback comes from a pin, so synchronise before gating
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fb_meta_q <= 1'b0;
      fb_sync_q <= 1'b0;
    end
    else
    begin
      fb_meta_q <= pulse_fb_in;
      fb_sync_q <= fb_meta_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      fb_q <= 1'b0;
    else
      fb_q <= fb_sync_q & active_q;
  end

  // Status flags come from flops so the outputs never glitch
  always_ff @(posedge clk)
  begin
    if (rst)
      reduce_q <= 1'b0;
    else
      reduce_q <= (cluster_count > clu_lim_q) && (neighbour_level >= clu_sig_q);
  end

  // Raw compare, so odd threshold settings cannot open a weak link
  always_ff @(posedge clk)
  begin
    if (rst)
      link_ok_q <= 1'b0;
    else
      link_ok_q <= (signal_level >= min_signal_threshold);
  end

  // Active-high lamp drive; sink wiring sees inverted patterns
  assign signal_tx_lamp           = sig_lamp_q;
  assign link_rx_lamp             = link_lamp_q;
  assign pulse_fb_out             = fb_q;
  assign lamps_enabled            = active_q;
  assign on_time                  = on_time_q;
  assign cluster_signal_threshold = clu_sig_q;
  assign cluster_limit            = clu_lim_q;
  assign cluster_reduce           = reduce_q;
  assign new_link_allowed         = link_ok_q;
endmodule : mli_top

// *** mli_top_asserts.sv ***
// Checker for the indicator lamp controller ports
`timescale 1ns/10ps
module mli_top_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Watched inputs
  input wire logic [2:0] role,
  input wire logic       config_mode,
  input wire logic       fixed_dest,
  input wire logic       end_node_cmd,
  input wire logic [7:0] signal_level,
  input wire logic [7:0] min_signal_threshold,
  input wire logic [7:0] cluster_count,
  input wire logic [7:0] neighbour_level,
  // Watched outputs
  input wire logic       signal_tx_lamp,
  input wire logic       link_rx_lamp,
  input wire logic       pulse_fb_out,
  input wire logic       lamps_enabled,
  input wire logic [7:0] on_time,
  input wire logic [7:0] cluster_signal_threshold,
  input wire logic [7:0] cluster_limit,
  input wire logic       cluster_reduce,
  input wire logic       new_link_allowed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Expected status flags, one cycle behind their inputs like the outputs
  logic reduce_exp_q;
  logic link_exp_q;

  always_ff @(posedge clk)
  begin
    reduce_exp_q <= (cluster_count > cluster_limit) &&
                    (neighbour_level >= cluster_signal_threshold);
    link_exp_q   <= (signal_level >= min_signal_threshold);
  end

  // Two cycles so the registered lamps have caught up
  sequence s_cfg_held;
    (config_mode && lamps_enabled)[*2];
  endsequence
  sequence s_off_held;
    (!lamps_enabled)[*2];
  endsequence
  // Config mode outranks the time-out, so dark lamps are expected only outside it
  sequence s_dark_held;
    (!lamps_enabled && !config_mode)[*2];
  endsequence
  sequence s_fixed_held;
    (fixed_dest && !config_mode && role != 3'h1 && lamps_enabled)[*2];
  endsequence

  chk_cfg_lamps_on: assert property (s_cfg_held |-> signal_tx_lamp && link_rx_lamp)
    else $error("lamps not lit in configuration mode");
  chk_off_dark: assert property (s_dark_held |-> !signal_tx_lamp && !link_rx_lamp)
    else $error("lamp lit after time-out");
  chk_fb_gated: assert property (s_off_held |-> !pulse_fb_out)
    else $error("feedback output active after time-out");
  chk_zero_disables: assert property (on_time == 8'h00 |=> !lamps_enabled)
    else $error("zero on-time left lamps enabled");
  chk_forever_on: assert property (on_time == 8'hff |=> lamps_enabled)
    else $error("permanent on-time timed out");
  chk_end_load: assert property (end_node_cmd |=> on_time == 8'h01)
    else $error("end node command did not load one minute");
  chk_reduce_rule: assert property (!$past(rst) |-> cluster_reduce == reduce_exp_q)
    else $error("cluster reduction flag wrong");
  chk_new_link: assert property (!$past(rst) |-> new_link_allowed == link_exp_q)
    else $error("new link permission wrong");
  chk_fixed_sync: assert property (s_fixed_held |-> link_rx_lamp == signal_tx_lamp)
    else $error("link lamp not in step with signal lamp");
endmodule : mli_top_chk

bind mli_top mli_top_chk u_chk (.clk, .rst, .role, .config_mode, .fixed_dest, .end_node_cmd,
  .signal_level, .min_signal_threshold, .cluster_count, .neighbour_level, .signal_tx_lamp,
  .link_rx_lamp, .pulse_fb_out, .lamps_enabled, .on_time, .cluster_signal_threshold,
  .cluster_limit, .cluster_reduce, .new_link_allowed);

// *** mli_lamp_mon.sv ***
// Lamp watcher standing in for the lamp or monitoring controller
`timescale 1ns/10ps
module mli_lamp_mon (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Lamp pin, high lights it
  input  wire logic       lamp,
  output logic      [7:0] flashes
);
  logic lamp_q;
  // Counts lit edges; a sink-wired lamp would show them inverted
  always_ff @(posedge clk)
  begin
    lamp_q <= lamp;
    if (rst)
      flashes <= 8'h00;
    else if (lamp && !lamp_q)
      flashes <= flashes + 8'h01;
  end
endmodule : mli_lamp_mon

// *** tb.sv ***
// Self-checking testbench for the indicator lamp controller
`timescale 1ns/10ps
module tb;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] role = 3'h2, topology = 3'h0;
  logic       end_node_cmd = 1'b0, on_time_wr = 1'b0, config_mode = 1'b0, fixed_dest = 1'b0;
  logic       cluster_sig_wr = 1'b0, cluster_lim_wr = 1'b0, tx_packet = 1'b0, rx_packet = 1'b0;
  logic       rx_valid = 1'b0, pulse_fb_in = 1'b0;
  logic [7:0] on_time_wdata = 8'h00, cluster_sig_wdata = 8'h00, cluster_lim_wdata = 8'h00;
  logic [7:0] signal_level = 8'h80, top_signal_threshold = 8'hc0, min_signal_threshold = 8'h40;
  logic [7:0] link_switch_margin = 8'h10, cluster_count = 8'h00, neighbour_level = 8'h00;
  logic       signal_tx_lamp, link_rx_lamp, pulse_fb_out, lamps_enabled, cluster_reduce;
  logic       new_link_allowed;
  logic [7:0] on_time, cluster_signal_threshold, cluster_limit, tx_seen, rx_seen;
  int         error_cnt = 0, checks = 0;

  mli_top dut (.clk, .rst, .role, .end_node_cmd, .on_time_wr, .on_time_wdata, .config_mode,
    .fixed_dest, .cluster_sig_wr, .cluster_sig_wdata, .cluster_lim_wr, .cluster_lim_wdata,
    .signal_level, .top_signal_threshold, .min_signal_threshold, .link_switch_margin, .topology,
    .tx_packet, .rx_packet, .rx_valid, .pulse_fb_in, .cluster_count, .neighbour_level,
    .signal_tx_lamp, .link_rx_lamp, .pulse_fb_out, .lamps_enabled, .on_time,
    .cluster_signal_threshold, .cluster_limit, .cluster_reduce, .new_link_allowed);
  mli_lamp_mon u_tx (.clk, .rst, .lamp(signal_tx_lamp), .flashes(tx_seen));
  mli_lamp_mon u_rx (.clk, .rst, .lamp(link_rx_lamp), .flashes(rx_seen));

  initial
  begin
    forever #20 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic do_reset;
    rst = 1'b1;
    step(16);
    rst = 1'b0;
    step(1);
  endtask : do_reset

  task automatic t_reset;
    chk(on_time, 8'hff);
    chk(8'(lamps_enabled), 8'h01);
    chk(cluster_signal_threshold, 8'h3c);
    chk(cluster_limit, 8'h0a);
    $display("test reset done");
  endtask : t_reset

  task automatic t_config;
    config_mode = 1'b1;
    step(3);
    chk({6'h00, signal_tx_lamp, link_rx_lamp}, 8'h03);
    config_mode = 1'b0;
    step(3);
    chk(8'(link_rx_lamp), 8'h00);
    topology = 3'h1;
    step(2);
    chk(8'(link_rx_lamp), 8'h01);
    topology = 3'h0;
    fixed_dest = 1'b1;
    step(4);
    fixed_dest = 1'b0;
    $display("test config done");
  endtask : t_config

  task automatic t_gateway;
    role = 3'h1;
    do_reset();
    rx_packet = 1'b1;
    step(1);
    rx_packet = 1'b0;
    step(3);
    chk(8'(link_rx_lamp), 8'h00);
    tx_packet = 1'b1;
    step(1);
    tx_packet = 1'b0;
    step(2);
    chk(8'(signal_tx_lamp), 8'h01);
    chk(tx_seen, 8'h01);
    rx_packet = 1'b1;
    rx_valid = 1'b1;
    step(1);
    rx_packet = 1'b0;
    rx_valid = 1'b0;
    step(2);
    chk(rx_seen, 8'h01);
    role = 3'h2;
    $display("test gateway done");
  endtask : t_gateway

  task automatic t_on_time;
    do_reset();
    end_node_cmd = 1'b1;
    on_time_wr = 1'b1;
    on_time_wdata = 8'h05;
    step(1);
    end_node_cmd = 1'b0;
    on_time_wr = 1'b0;
    step(1);
    chk(on_time, 8'h01);
    pulse_fb_in = 1'b1;
    step(4);
    chk(8'(pulse_fb_out), 8'h01);
    on_time_wr = 1'b1;
    on_time_wdata = 8'h00;
    step(1);
    on_time_wr = 1'b0;
    step(4);
    chk(8'(lamps_enabled), 8'h00);
    chk({6'h00, signal_tx_lamp, link_rx_lamp}, 8'h00);
    chk(8'(pulse_fb_out), 8'h00);
    config_mode = 1'b1;
    step(3);
    chk({6'h00, signal_tx_lamp, link_rx_lamp}, 8'h03);
    config_mode = 1'b0;
    on_time_wr = 1'b1;
    on_time_wdata = 8'hff;
    step(1);
    on_time_wr = 1'b0;
    step(3);
    chk(8'(lamps_enabled), 8'h01);
    pulse_fb_in = 1'b0;
    $display("test on-time done");
  endtask : t_on_time

  task automatic t_cluster;
    cluster_sig_wr = 1'b1;
    cluster_sig_wdata = 8'h50;
    cluster_lim_wr = 1'b1;
    cluster_lim_wdata = 8'h03;
    step(1);
    cluster_sig_wr = 1'b0;
    cluster_lim_wr = 1'b0;
    cluster_count = 8'h03;
    neighbour_level = 8'h50;
    step(1);
    chk(cluster_signal_threshold, 8'h50);
    chk(cluster_limit, 8'h03);
    chk(8'(cluster_reduce), 8'h00);
    cluster_count = 8'h04;
    step(1);
    chk(8'(cluster_reduce), 8'h01);
    neighbour_level = 8'h4f;
    signal_level = 8'h3f;
    step(1);
    chk({6'h00, cluster_reduce, new_link_allowed}, 8'h00);
    signal_level = 8'h40;
    step(1);
    chk(8'(new_link_allowed), 8'h01);
    $display("test cluster done");
  endtask : t_cluster

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  initial
  begin
    do_reset();
    t_reset();
    t_config();
    t_gateway();
    t_on_time();
    t_cluster();
    give_verdict();
  end
endmodule : tb
